// *** logic/tcrb_timer.sv ***
module tcrb_timer (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // avalon-mm slave
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // external pins
   input wire logic trigger_dir_pin_i,
   input wire logic count_clkout_pin_i,
   output logic count_clkout_pin_o,
   output logic count_clkout_pin_oe_n_o,
   // serial port baud sources
   input wire logic t1_ovf_i,
   output logic tx_baud_tick_o,
   output logic rx_baud_tick_o,
   // interrupt request
   output logic irq_o
);
   // ==========================================================
   // registers
   // ==========================================================
   tcrb_pkg::tcrb_ctrl_s ctrl_reg, ctrl_next;
   logic [1:0] mode_reg, mode_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [15:0] caprel_reg, caprel_next;
   logic irqen_reg, irqen_next;
   logic [2:0] mc_cnt_reg;
   logic mc_en;
   logic trg_a_reg, trg_b_reg;
   logic cpin_a_reg, cpin_b_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic pin_out_reg, oe_n_reg, irq_reg, tx_tick_reg, rx_tick_reg;

   // ==========================================================
   // bus decode
   // ==========================================================
   wire req = avs_read_i | avs_write_i;
   wire acc_wr = avs_write_i & ~wait_reg;
   wire sel_ctrl = avs_address_i == tcrb_pkg::OFS_CTRL;
   wire sel_mode = avs_address_i == tcrb_pkg::OFS_MODE;
   wire sel_cnt = avs_address_i == tcrb_pkg::OFS_COUNT;
   wire sel_cap = avs_address_i == tcrb_pkg::OFS_CAPREL;
   wire sel_irq = avs_address_i == tcrb_pkg::OFS_IRQEN;
   wire wr_ctrl = acc_wr & sel_ctrl & avs_byteenable_i[0];
   wire wr_mode = acc_wr & sel_mode & avs_byteenable_i[0];
   wire wr_irq = acc_wr & sel_irq & avs_byteenable_i[0];
   wire wr_cnt_lo = acc_wr & sel_cnt & avs_byteenable_i[0];
   wire wr_cnt_hi = acc_wr & sel_cnt & avs_byteenable_i[1];
   wire wr_cap_lo = acc_wr & sel_cap & avs_byteenable_i[0];
   wire wr_cap_hi = acc_wr & sel_cap & avs_byteenable_i[1];
   wire [7:0] wd = avs_writedata_i[7:0];
   wire [7:0] wd_hi = avs_writedata_i[15:8];
   // unmapped offsets read as zero
   wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_reg} :
                        sel_mode ? {30'h00000000, mode_reg} :
                        sel_cnt ? {16'h0000, cnt_reg} :
                        sel_cap ? {16'h0000, caprel_reg} :
                        sel_irq ? {31'h00000000, irqen_reg} : 32'h00000000;

   // ==========================================================
   // mode decode
   // ==========================================================
   wire baud = ctrl_reg.tx_baud_select | ctrl_reg.rx_baud_select;
   wire cap_mode = ctrl_reg.capture_reload_select & ~baud;
   wire clkout = ~baud & ~ctrl_reg.capture_reload_select & mode_reg[tcrb_pkg::MB_CLKOE];
   wire updown = mode_reg[tcrb_pkg::MB_DOWN_COUNT_ENABLE] & ~cap_mode & ~baud & ~clkout;
   wire down = updown & ~trg_a_reg;
   wire fast = baud | clkout;
   wire pin_fall = mc_en & cpin_b_reg & ~cpin_a_reg;
   wire ext_fall = mc_en & trg_b_reg & ~trg_a_reg;
   wire ext_hit = ext_fall & ctrl_reg.ext_trigger_enable;
   // timer ticks: osc rate for baud and clock-out, machine cycle otherwise
   wire tick = ctrl_reg.run_bit &
               (ctrl_reg.timer_counter_select ? pin_fall : (fast | mc_en));
   wire at_end = down ? (cnt_reg == caprel_reg) : (cnt_reg == tcrb_pkg::COUNT_TOP);
   wire roll = tick & at_end;
   wire [15:0] reload_val = down ? tcrb_pkg::COUNT_TOP : caprel_reg;
   wire cap_hit = ext_hit & cap_mode;
   wire ext_reload = ext_hit & ~cap_mode & ~baud & ~updown;
   wire ovf_set = roll & ~baud & ~clkout;
   wire ext_set = ext_hit & ~updown;
   wire ext_tgl = roll & updown;
   wire [15:0] step = down ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;

   // ==========================================================
   // next-state logic
   // ==========================================================
   always_comb begin
      cnt_next = cnt_reg;
      if (roll) begin
         cnt_next = cap_mode ? 16'h0000 : reload_val;
      end else if (ext_reload) begin
         cnt_next = caprel_reg;
      end else if (tick) begin
         cnt_next = step;
      end
      if (wr_cnt_lo) begin
         cnt_next[7:0] = wd;
      end
      if (wr_cnt_hi) begin
         cnt_next[15:8] = wd_hi;
      end
   end

   always_comb begin
      caprel_next = cap_hit ? cnt_reg : caprel_reg;
      if (wr_cap_lo) begin
         caprel_next[7:0] = wd;
      end
      if (wr_cap_hi) begin
         caprel_next[15:8] = wd_hi;
      end
   end

   always_comb begin
      ctrl_next = wr_ctrl ? tcrb_pkg::tcrb_ctrl_s'(wd) : ctrl_reg;
      // software may only clear flags; a hardware set wins
      ctrl_next.ovf_flag = ovf_set |
                           (ctrl_reg.ovf_flag & ~(wr_ctrl & ~wd[tcrb_pkg::CB_OVF]));
      ctrl_next.ext_event_flag = ext_set |
                                 (ctrl_reg.ext_event_flag & ~(wr_ctrl & ~wd[tcrb_pkg::CB_EXT]));
      if (ext_tgl) begin
         ctrl_next.ext_event_flag = ~ctrl_reg.ext_event_flag;
      end
   end

   assign mode_next = wr_mode ? wd[1:0] : mode_reg;
   assign irqen_next = wr_irq ? wd[0] : irqen_reg;
   assign mc_en = mc_cnt_reg == (tcrb_pkg::MC_DIV - 3'h1);

   // ==========================================================
   // sequential
   // ==========================================================
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         ctrl_reg <= tcrb_pkg::CTRL_RST;
         mode_reg <= tcrb_pkg::MODE_RST;
         cnt_reg <= tcrb_pkg::COUNT_RST;
         caprel_reg <= tcrb_pkg::CAPREL_RST;
         irqen_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         mode_reg <= mode_next;
         cnt_reg <= cnt_next;
         caprel_reg <= caprel_next;
         irqen_reg <= irqen_next;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         mc_cnt_reg <= 3'h0;
      end else begin
         mc_cnt_reg <= mc_en ? 3'h0 : mc_cnt_reg + 3'h1;
      end
   end

   // pin samples once per machine cycle
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         trg_a_reg <= 1'b1;
         trg_b_reg <= 1'b1;
         cpin_a_reg <= 1'b1;
         cpin_b_reg <= 1'b1;
      end else if (mc_en) begin
         trg_a_reg <= trigger_dir_pin_i;
         trg_b_reg <= trg_a_reg;
         cpin_a_reg <= count_clkout_pin_i;
         cpin_b_reg <= cpin_a_reg;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
      end else begin
         wait_reg <= ~(req & wait_reg);
         if (avs_read_i & wait_reg) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         pin_out_reg <= 1'b0;
         oe_n_reg <= 1'b1;
         irq_reg <= 1'b0;
         tx_tick_reg <= 1'b0;
         rx_tick_reg <= 1'b0;
      end else begin
         if (roll & clkout) begin
            pin_out_reg <= ~pin_out_reg;
         end
         oe_n_reg <= ~clkout;
         irq_reg <= irqen_next & (ctrl_next.ovf_flag | ctrl_next.ext_event_flag);
         tx_tick_reg <= ctrl_reg.tx_baud_select ? roll : t1_ovf_i;
         rx_tick_reg <= ctrl_reg.rx_baud_select ? roll : t1_ovf_i;
      end
   end

   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign count_clkout_pin_o = pin_out_reg;
   assign count_clkout_pin_oe_n_o = oe_n_reg;
   assign irq_o = irq_reg;
   assign tx_baud_tick_o = tx_tick_reg;
   assign rx_baud_tick_o = rx_tick_reg;

   // ==========================================================
   // assertions
   // ==========================================================
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (reset_i);

   wire no_cnt_wr = ~(wr_cnt_lo | wr_cnt_hi);

   a_capture_wrap: assert property (
      roll & cap_mode & no_cnt_wr |=> cnt_reg == 16'h0000 && ctrl_reg.ovf_flag)
      else $error("capture mode overflow did not wrap and flag");
   a_capture_copy: assert property (
      cap_hit & ~(wr_cap_lo | wr_cap_hi) |=> caprel_reg == $past(cnt_reg))
      else $error("capture did not copy counter");
   a_ext_flag_set: assert property (
      ext_set |=> ctrl_reg.ext_event_flag)
      else $error("trigger edge did not set external flag");
   a_up_reload: assert property (
      roll & ~down & ~cap_mode & no_cnt_wr |=> cnt_reg == $past(caprel_reg))
      else $error("up overflow did not reload");
   a_down_reload: assert property (
      roll & down & no_cnt_wr |=> cnt_reg == 16'hffff && ctrl_reg.ovf_flag)
      else $error("underflow did not load ffff");
   a_irq_sources: assert property (
      irq_o == (irqen_reg & (ctrl_reg.ovf_flag | ctrl_reg.ext_event_flag)))
      else $error("interrupt does not match flags");
   a_ext_toggle: assert property (
      ext_tgl |=> ctrl_reg.ext_event_flag != $past(ctrl_reg.ext_event_flag))
      else $error("external flag did not toggle");
   a_baud_no_flag: assert property (
      roll & baud & ~ctrl_reg.ovf_flag |=> ~ctrl_reg.ovf_flag)
      else $error("baud rollover set overflow flag");
   a_clk_toggle: assert property (
      roll & clkout |=> count_clkout_pin_o != $past(count_clkout_pin_o))
      else $error("clock out did not toggle");
   a_bus_answer: assert property (
      req & avs_waitrequest_o |=> ~avs_waitrequest_o)
      else $error("bus request not answered in one cycle");

   c_capture: cover property (cap_hit);
   c_baud_roll: cover property (roll & baud);
   c_underflow: cover property (roll & down);
   c_clkout_roll: cover property (roll & clkout);
   c_ext_reload: cover property (ext_reload);

   // ==========================================================
   // counting assertions
   // ==========================================================
   // each check of the count value steps aside when software writes the counter

   a_capture_run: assert property (
      cap_hit & tick & ~at_end & no_cnt_wr |=> cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("capture disturbed the count");

   a_up_step: assert property (
      tick & ~at_end & ~down & ~ext_reload & no_cnt_wr |=> cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("up count did not step by one");

   a_down_step: assert property (
      tick & ~at_end & down & no_cnt_wr |=> cnt_reg == $past(cnt_reg) - 16'h0001)
      else $error("down count did not step by one");

   a_timer_rate: assert property (
      ~fast & ~ctrl_reg.timer_counter_select & ~mc_en & no_cnt_wr |=> $stable(cnt_reg))
      else $error("timer moved between machine cycles");

   a_counter_edge: assert property (
      ctrl_reg.timer_counter_select & ~pin_fall & ~ext_reload & no_cnt_wr |=> $stable(cnt_reg))
      else $error("counter moved without a pin edge");

   a_run_stop: assert property (
      ~ctrl_reg.run_bit & ~ext_reload & no_cnt_wr |=> $stable(cnt_reg))
      else $error("stopped timer moved");

   a_ext_reload: assert property (
      ext_reload & ~roll & no_cnt_wr |=> cnt_reg == $past(caprel_reg))
      else $error("trigger edge did not reload");

   a_baud_no_reload: assert property (
      ext_hit & baud & ~tick & no_cnt_wr |=> $stable(cnt_reg))
      else $error("trigger edge reloaded in baud mode");

   a_baud_ext_flag: assert property (
      ext_hit & baud |=> ctrl_reg.ext_event_flag)
      else $error("trigger edge did not flag in baud mode");

   a_updown_no_edge: assert property (
      updown |-> ~ext_reload && ~ext_set)
      else $error("trigger edge acted in up/down mode");

   a_capture_baud: assert property (
      baud |-> ~cap_hit)
      else $error("capture taken while a baud select is set");

   // ==========================================================
   // flag assertions
   // ==========================================================

   a_clkout_no_flag: assert property (
      roll & clkout & ~ctrl_reg.ovf_flag |=> ~ctrl_reg.ovf_flag)
      else $error("clock-out rollover set overflow flag");

   a_flag_clear: assert property (
      wr_ctrl & ~wd[tcrb_pkg::CB_OVF] & ~ovf_set |=> ~ctrl_reg.ovf_flag)
      else $error("software clear of overflow flag lost");

   a_flag_hw_wins: assert property (
      ovf_set |=> ctrl_reg.ovf_flag)
      else $error("hardware set of overflow flag lost");

   a_ovf_sticky: assert property (
      ctrl_reg.ovf_flag & ~wr_ctrl |=> ctrl_reg.ovf_flag)
      else $error("overflow flag cleared without software");

   a_no_sw_set: assert property (
      ~ctrl_reg.ovf_flag & ~ovf_set |=> ~ctrl_reg.ovf_flag)
      else $error("overflow flag set without an overflow");

   // ==========================================================
   // pin and baud source assertions
   // ==========================================================

   a_tx_source: assert property (
      ~ctrl_reg.tx_baud_select |=> tx_baud_tick_o == $past(t1_ovf_i))
      else $error("transmit tick not from other timer");

   a_tx_own: assert property (
      ctrl_reg.tx_baud_select |=> tx_baud_tick_o == $past(roll))
      else $error("transmit tick not from this timer");

   a_rx_source: assert property (
      ~ctrl_reg.rx_baud_select |=> rx_baud_tick_o == $past(t1_ovf_i))
      else $error("receive tick not from other timer");

   a_rx_own: assert property (
      ctrl_reg.rx_baud_select |=> rx_baud_tick_o == $past(roll))
      else $error("receive tick not from this timer");

   a_oe_mode: assert property (
      clkout |=> ~count_clkout_pin_oe_n_o)
      else $error("pin not driven in clock-out mode");

   a_pin_hold: assert property (
      ~(roll & clkout) |=> $stable(count_clkout_pin_o))
      else $error("clock out moved without a rollover");

   // ==========================================================
   // bus assertions
   // ==========================================================

   a_wait_idle: assert property (
      ~req |=> avs_waitrequest_o)
      else $error("waitrequest low without a request");
endmodule // tcrb_timer

// *** shared/tcrb_pkg.sv ***
// Notes on behaviour
// - capture, no trigger: plain 16-bit count, overflow flag
// - trigger fall copies count into capture bytes
// - capture fall sets external flag too
// - capture mode never reloads the counter
// - each later fall overwrites both capture bytes
// - reset clears down-count; then pin sets direction
// - up count to ffff, flag, reload
// - trigger fall also reloads, sets external flag
// - interrupt when enabled and either flag set
// - fall seen over two machine cycles
// - down-count enabled, pin high: count up
// - pin low: count down, underflow at reload, load ffff
// - up/down mode toggles external flag per wrap
// - clock out is osc over twice span
// - clock-out rollovers raise no interrupt
// - select bits pick baud source per direction
// - baud mode counts osc clocks, reloads on rollover
// - baud rollover sets no flag, no interrupt
// - baud mode trigger fall flags without reload
// - timer elsewhere counts once per machine cycle
// - baud select forces auto-reload, ignores capture select
// - overflow flag set by hardware, cleared by software
package tcrb_pkg;
   // register byte offsets
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_MODE = 5'h04;
   localparam logic [4:0] OFS_COUNT = 5'h08;
   localparam logic [4:0] OFS_CAPREL = 5'h0c;
   localparam logic [4:0] OFS_IRQEN = 5'h10;
   // control register bit positions
   localparam int CB_OVF = 7;
   localparam int CB_EXT = 6;
   localparam int CB_RXSEL = 5;
   localparam int CB_TXSEL = 4;
   localparam int CB_EXTEN = 3;
   localparam int CB_RUN = 2;
   localparam int CB_CTS = 1;
   localparam int CB_CPRL = 0;
   // mode register bit positions
   localparam int MB_CLKOE = 1;
   localparam int MB_DOWN_COUNT_ENABLE = 0;
   // reset values and count top
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] CAPREL_RST = 16'h0000;
   localparam logic [15:0] COUNT_TOP = 16'hffff;
   // oscillator clocks per machine cycle
   localparam logic [2:0] MC_DIV = 3'h6;
   typedef struct packed {
      logic ovf_flag;
      logic ext_event_flag;
      logic rx_baud_select;
      logic tx_baud_select;
      logic ext_trigger_enable;
      logic run_bit;
      logic timer_counter_select;
      logic capture_reload_select;
   } tcrb_ctrl_s;
endpackage

// *** verification/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [4:0] A_CT = tcrb_pkg::OFS_CTRL;
   localparam logic [4:0] A_MD = tcrb_pkg::OFS_MODE;
   localparam logic [4:0] A_CN = tcrb_pkg::OFS_COUNT;
   localparam logic [4:0] A_CR = tcrb_pkg::OFS_CAPREL;
   localparam logic [4:0] A_IE = tcrb_pkg::OFS_IRQEN;
   logic clk, reset_i, rd, wr, wreq, trig, cnt_drv, pin_o, oe_n, pin_w, t1, txt, rxt, irq, prev;
   logic [4:0] adr;
   logic [31:0] wdat, rdat;
   int n_mismatch, total_checks, cyc, n_tx, n_rx, ntog, n0, n1;
   logic [31:0] rdat_q;
   assign pin_w = oe_n ? cnt_drv : pin_o;
   always #2 clk = ~clk;
   tcrb_timer dut_u (.ref_clk_i(clk), .reset_i(reset_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .trigger_dir_pin_i(trig),
      .count_clkout_pin_i(pin_w), .count_clkout_pin_o(pin_o), .count_clkout_pin_oe_n_o(oe_n),
      .t1_ovf_i(t1), .tx_baud_tick_o(txt), .rx_baud_tick_o(rxt), .irq_o(irq));
   tcrb_far_end far_u (.ref_clk_i(clk), .tx_baud_tick_i(txt), .rx_baud_tick_i(rxt),
      .t1_ovf_o(t1), .n_tx_o(n_tx), .n_rx_o(n_rx));
   // =====================================
   // tasks
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      // the bench timeout ends a wait that never finishes
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic bw(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      acc(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic rst(input string name);
      $display("test %s done", name);
      @(posedge clk);
      reset_i <= 1'b1;
      trig <= 1'b1;
      cnt_drv <= 1'b1;
      repeat (5) @(posedge clk);
      reset_i <= 1'b0;
   endtask
   always @(posedge clk) begin
      prev <= pin_o;
      if (pin_o !== prev) ntog++;
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   // =====================================
   // main sequence
   initial begin
      clk = 0; reset_i = 1; rd = 0; wr = 0; adr = 5'h00; wdat = 32'h0; trig = 1; cnt_drv = 1;
      prev = 0; n_mismatch = 0; total_checks = 0; cyc = 0; ntog = 0;
      rst("start");
      rc(A_CT, 32'h0); rc(A_MD, 32'h0);
      rc(A_CN, 32'h0); rc(5'h14, 32'h0);
      bw(A_CN, 32'h5a5a); bw(A_CT, 32'h0f); wt(12);
      @(posedge clk) trig <= 1'b0;
      wt(24); rc(A_CR, 32'h5a5a); rc(A_CT, 32'h4f);
      bw(A_IE, 32'h1); wt(2); chk(irq, 1'b1);
      bw(A_CT, 32'h0f); wt(2); chk(irq, 1'b0);
      @(posedge clk) cnt_drv <= 1'b0;
      wt(12);
      @(posedge clk) cnt_drv <= 1'b1;
      @(posedge clk) trig <= 1'b1;
      wt(12);
      @(posedge clk) trig <= 1'b0;
      wt(24); rc(A_CN, 32'h5a5b); rc(A_CR, 32'h5a5b);
      rst("capture");
      bw(A_CR, 32'h1234); bw(A_CN, 32'hfffe); bw(A_CT, 32'h04); wt(30);
      rc(A_CT, 32'h84); acc(1'b0, A_CN, 32'h0, rdat_q); chk(rdat_q[15:4], 12'h123);
      rst("reload");
      trig <= 1'b0;
      bw(A_MD, 32'h1); bw(A_CR, 32'h1000); bw(A_CN, 32'h1002); bw(A_CT, 32'h04); wt(60);
      rc(A_CT, 32'hc4); acc(1'b0, A_CN, 32'h0, rdat_q); chk(rdat_q[15:8], 8'hff);
      rst("updown");
      bw(A_CR, 32'hfff0); bw(A_CN, 32'hfff0); bw(A_IE, 32'h1); bw(A_CT, 32'h14); wt(8);
      n0 = n_tx; n1 = n_rx; wt(160);
      chk(((n_tx - n0) inside {[9:11]}), 1'b1);
      chk(((n_rx - n1) inside {[19:21]}), 1'b1);
      rc(A_CT, 32'h14); chk(irq, 1'b0);
      rst("baud");
      bw(A_MD, 32'h2); bw(A_CR, 32'hfffc); bw(A_CN, 32'hfffc); bw(A_IE, 32'h1);
      bw(A_CT, 32'h04); wt(8);
      n0 = ntog; wt(80);
      chk(((ntog - n0) inside {[19:21]}), 1'b1);
      chk(oe_n, 1'b0); chk(irq, 1'b0); rc(A_CT, 32'h04);
      rst("clockout");
      conclude();
   end
endmodule // tb_top

// *** verification/tcrb_far_end.sv ***
module tcrb_far_end (
   // clock
   input wire logic ref_clk_i,
   // baud ticks from the timer
   input wire logic tx_baud_tick_i,
   input wire logic rx_baud_tick_i,
   // other timer and tick tallies
   output logic t1_ovf_o,
   output int n_tx_o,
   output int n_rx_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] div_reg;
   initial begin
      div_reg = 3'h0;
      t1_ovf_o = 1'b0;
      n_tx_o = 0;
      n_rx_o = 0;
   end
   // =====================================
   // other timer overflows every 8 clocks, uart tallies ticks
   always @(posedge ref_clk_i) begin
      div_reg <= div_reg + 3'h1;
      t1_ovf_o <= (div_reg == 3'h7);
      n_tx_o <= n_tx_o + int'(tx_baud_tick_i);
      n_rx_o <= n_rx_o + int'(rx_baud_tick_i);
   end
endmodule // tcrb_far_end
